// ### shared/strobe_seg_consts.vh
// constants for the strobe routing and buffer segmentation register bank
// assumes inclusion by bare name from design files under hdl/
`ifndef STROBE_SEG_CONSTS_VH
`define STROBE_SEG_CONSTS_VH
// register byte addresses on apb
`define ADDR_STROBE_PORT_ENABLES 12'h000
`define ADDR_BUFFER_DATA_SIZE 12'h004
`define ADDR_SEGMENT_SPLIT_USE 12'h008
`define ADDR_STROBE_SELECT 12'h00c
`define ADDR_BUFFER_QUERY 12'h010
`define ADDR_BUFFER_INFO 12'h014
// reset values
`define RST_PORT_ENABLES 4'h0
`define RST_SEG_SIZE 7'h00
`define RST_BUF_NUM 7'h00
`define RST_SELECT 7'h00
`define RST_ROUTE 2'h0
// field positions
`define PEN_MSB 3
`define HI_MSB 14
`define HI_LSB 8
`define LO_MSB 6
`define LO_LSB 0
`define SEL_MSB 6
`define SLOT_IDX_MSB 3
// bit positions in the buffer info word
`define INFO_EMPTY_BIT 2
`define INFO_SEG2_BIT 1
`define INFO_SEARCHED_BIT 0
// highest buffer number
`define LAST_BUF_NUM 7'h7f
// route codes of the four strobe ports
`define ROUTE_PORT_0 2'h0
`define ROUTE_PORT_1 2'h1
`define ROUTE_PORT_2 2'h2
`define ROUTE_PORT_3 2'h3
`define ROUTE_MSB 9
`define ROUTE_LSB 8
// strobe select codes
`define SEL_SLOTB_FIRST 7'h41
`define SEL_SLOTB_LAST 7'h4b
`define SEL_CYCLE_START 7'h4c
`define SEL_MINISLOT_START 7'h4f
// offsets to macrotick start, in protocol engine clocks
`define OFFSET_SLOT_B 0
`define OFFSET_CYCLE_START 0
`define OFFSET_MINISLOT_START 0
`define BUF_LIMIT 8'h80
`endif

// ### hdl/strobe_seg_regs.v
// apb register bank: debug strobe routing and message buffer segment setup
// assumes pclk is the protocol engine clock; pe sources are synchronous to it
//
// Function
// - select codes 0x41..0x4b show bits 0..10 of the channel b slot counter, zero offset to macrotick start.
// - code 0x4c gives a cycle start pulse and 0x4f a minislot start pulse, channel free, zero offset.
// - all strobe offsets are counted in protocol engine clock cycles.
// - a port with its enable cleared stays inactive even with signals routed to it.
// - the port enable register has bits 3..0 for ports 3..0, 1 enables and 0 disables.
// - the data size register holds second segment size in bits 14..8 and first in 6..0, in two-byte units.
// - two independent segments exist, each with one data size of its own.
// - boundary bits 14..8 name the last buffer of segment one, which holds buffers up to and including it.
// - buffers above the boundary and below 128 form segment two, empty when the boundary is 127.
// - last-used bits 6..0 limit the search to buffers numbered up to that value.
// - when last-used equals the boundary, the second segment is treated as empty.
// - a two-bit route sends the chosen strobe to port 0..3, and signals on one port are combined by or; here only the one selected strobe reaches a port.
`include "strobe_seg_consts.vh"

module strobe_seg_regs (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire [10:0] slot_count_b,
    input wire cycle_start,
    input wire minislot_start,
    output reg strobe_port_0,
    output reg strobe_port_1,
    output reg strobe_port_2,
    output reg strobe_port_3,
    output wire [6:0] first_segment_size,
    output wire [6:0] second_segment_size,
    output wire [6:0] first_segment_end,
    output wire [6:0] last_used_buffer,
    output wire second_segment_empty
);

    // register file, one flop per field bit
    reg [3:0] port_on_ff;
    reg [6:0] seg1_size_ff;
    reg [6:0] seg2_size_ff;
    reg [6:0] seg1_end_ff;
    reg [6:0] last_used_ff;
    reg [6:0] select_ff;
    reg [1:0] strobe_port_route_ff;
    reg [6:0] query_ff;

    // next values of the register file
    reg [3:0] nxt_port_on;
    reg [6:0] nxt_seg1_size;
    reg [6:0] nxt_seg2_size;
    reg [6:0] nxt_seg1_end;
    reg [6:0] nxt_last_used;
    reg [6:0] nxt_select;
    reg [1:0] nxt_route;
    reg [6:0] nxt_query;

    // bus decode
    reg [31:0] nxt_prdata;
    wire access;
    wire setup_rd;
    wire wr_en;
    wire addr_ok;
    wire hit_port_on;
    wire hit_size;
    wire hit_split;
    wire hit_select;
    wire hit_query;
    wire hit_info;

    // buffer classification
    wire q_searched;
    wire q_in_seg2;
    wire [6:0] q_size;
    wire boundary_full;
    wire used_in_seg1;

    // strobe path
    reg chosen;
    wire [6:0] slot_diff;
    wire sel_slot_b;
    wire sel_cycle;
    wire sel_minislot;
    wire [3:0] nxt_ports;

    // zero wait states; every access completes in its first access cycle
    assign pready = 1'b1;

    // address decode, one hit line per register
    assign hit_port_on = (paddr == `ADDR_STROBE_PORT_ENABLES);
    assign hit_size = (paddr == `ADDR_BUFFER_DATA_SIZE);
    assign hit_split = (paddr == `ADDR_SEGMENT_SPLIT_USE);
    assign hit_select = (paddr == `ADDR_STROBE_SELECT);
    assign hit_query = (paddr == `ADDR_BUFFER_QUERY);
    assign hit_info = (paddr == `ADDR_BUFFER_INFO);
    assign addr_ok = hit_port_on || hit_size || hit_split || hit_select || hit_query || hit_info;
    assign access = psel && penable;
    assign setup_rd = psel && !penable && !pwrite;
    // unmapped addresses answer with an error and leave every register alone
    assign pslverr = access && !addr_ok;
    // the info word is read-only, so a write to it changes nothing
    assign wr_en = access && pwrite && addr_ok && !hit_info;

    // next register values; a field keeps its value unless its own word is written
    always @* begin
        nxt_port_on = port_on_ff;
        nxt_seg1_size = seg1_size_ff;
        nxt_seg2_size = seg2_size_ff;
        nxt_seg1_end = seg1_end_ff;
        nxt_last_used = last_used_ff;
        nxt_select = select_ff;
        nxt_route = strobe_port_route_ff;
        nxt_query = query_ff;
        if (wr_en && hit_port_on) begin
            nxt_port_on = pwdata[`PEN_MSB:`LO_LSB];
        end
        if (wr_en && hit_size) begin
            nxt_seg2_size = pwdata[`HI_MSB:`HI_LSB];
            nxt_seg1_size = pwdata[`LO_MSB:`LO_LSB];
        end
        if (wr_en && hit_split) begin
            nxt_seg1_end = pwdata[`HI_MSB:`HI_LSB];
            nxt_last_used = pwdata[`LO_MSB:`LO_LSB];
        end
        // select and route share one word, so a new code never meets a stale port
        if (wr_en && hit_select) begin
            nxt_select = pwdata[`SEL_MSB:`LO_LSB];
            nxt_route = pwdata[`ROUTE_MSB:`ROUTE_LSB];
        end
        if (wr_en && hit_query) begin
            nxt_query = pwdata[`LO_MSB:`LO_LSB];
        end
    end

    // register file flops; a write lands at the access edge only
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_on_ff <= `RST_PORT_ENABLES;
            seg1_size_ff <= `RST_SEG_SIZE;
            seg2_size_ff <= `RST_SEG_SIZE;
            seg1_end_ff <= `RST_BUF_NUM;
            last_used_ff <= `RST_BUF_NUM;
            select_ff <= `RST_SELECT;
            strobe_port_route_ff <= `RST_ROUTE;
            query_ff <= `RST_BUF_NUM;
        end else begin
            port_on_ff <= nxt_port_on;
            seg1_size_ff <= nxt_seg1_size;
            seg2_size_ff <= nxt_seg2_size;
            seg1_end_ff <= nxt_seg1_end;
            last_used_ff <= nxt_last_used;
            select_ff <= nxt_select;
            strobe_port_route_ff <= nxt_route;
            query_ff <= nxt_query;
        end
    end

    // segment classification for the queried buffer number
    assign q_searched = (query_ff <= last_used_ff);
    assign q_in_seg2 = (query_ff > seg1_end_ff) && ({1'b0, query_ff} < `BUF_LIMIT);
    assign q_size = q_in_seg2 ? seg2_size_ff : seg1_size_ff;
    // boundary at the top buffer number leaves no room for segment two
    assign boundary_full = (seg1_end_ff == `LAST_BUF_NUM);
    // nothing past the boundary is ever searched, so segment two goes unused
    assign used_in_seg1 = (last_used_ff <= seg1_end_ff);
    assign second_segment_empty = boundary_full || used_in_seg1;
    assign first_segment_size = seg1_size_ff;
    assign second_segment_size = seg2_size_ff;
    assign first_segment_end = seg1_end_ff;
    assign last_used_buffer = last_used_ff;

    // read mux; unmapped reads return zero, fields sit in the low bits
    always @* begin
        nxt_prdata = 32'h00000000;
        case (paddr)
            `ADDR_STROBE_PORT_ENABLES: nxt_prdata[`PEN_MSB:`LO_LSB] = port_on_ff;
            `ADDR_BUFFER_DATA_SIZE: begin
                nxt_prdata[`HI_MSB:`HI_LSB] = seg2_size_ff;
                nxt_prdata[`LO_MSB:`LO_LSB] = seg1_size_ff;
            end
            `ADDR_SEGMENT_SPLIT_USE: begin
                nxt_prdata[`HI_MSB:`HI_LSB] = seg1_end_ff;
                nxt_prdata[`LO_MSB:`LO_LSB] = last_used_ff;
            end
            `ADDR_STROBE_SELECT: begin
                nxt_prdata[`SEL_MSB:`LO_LSB] = select_ff;
                nxt_prdata[`ROUTE_MSB:`ROUTE_LSB] = strobe_port_route_ff;
            end
            `ADDR_BUFFER_QUERY: nxt_prdata[`LO_MSB:`LO_LSB] = query_ff;
            // info word: size of the queried buffer's segment and three flags
            `ADDR_BUFFER_INFO: begin
                nxt_prdata[`HI_MSB:`HI_LSB] = q_size;
                nxt_prdata[`INFO_EMPTY_BIT] = second_segment_empty;
                nxt_prdata[`INFO_SEG2_BIT] = q_in_seg2 && !second_segment_empty;
                nxt_prdata[`INFO_SEARCHED_BIT] = q_searched;
            end
            default: nxt_prdata = 32'h00000000;
        endcase
    end

    // read data registered during setup so it stands stable in the access cycle
    // a write setup leaves it alone, so software sees the last read until the next
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (setup_rd) begin
            prdata <= nxt_prdata;
        end
    end

    // decode the select code once; codes outside the table drive nothing
    assign sel_slot_b = (select_ff >= `SEL_SLOTB_FIRST) && (select_ff <= `SEL_SLOTB_LAST);
    assign sel_cycle = (select_ff == `SEL_CYCLE_START);
    assign sel_minislot = (select_ff == `SEL_MINISLOT_START);
    // slot bit number is the code less the first slot code; only the low bits matter
    assign slot_diff = select_ff - `SEL_SLOTB_FIRST;

    // strobe source select; pe inputs are single-cycle pulses and live values
    always @* begin
        chosen = 1'b0;
        if (sel_slot_b) begin
            chosen = slot_count_b[slot_diff[`SLOT_IDX_MSB:`LO_LSB]];
        end else if (sel_cycle) begin
            chosen = cycle_start;
        end else if (sel_minislot) begin
            chosen = minislot_start;
        end
    end

    // one gate per port: routed here and enabled, or held low
    // with a single select word only one source reaches a port, so the or is trivial
    // port 0
    strobe_port_gate #(.PORT_NUM(`ROUTE_PORT_0)) gate_0 (
        .chosen(chosen),
        .route(strobe_port_route_ff),
        .enable(port_on_ff[0]),
        .drive(nxt_ports[0])
    );
    // port 1
    strobe_port_gate #(.PORT_NUM(`ROUTE_PORT_1)) gate_1 (
        .chosen(chosen),
        .route(strobe_port_route_ff),
        .enable(port_on_ff[1]),
        .drive(nxt_ports[1])
    );
    // port 2
    strobe_port_gate #(.PORT_NUM(`ROUTE_PORT_2)) gate_2 (
        .chosen(chosen),
        .route(strobe_port_route_ff),
        .enable(port_on_ff[2]),
        .drive(nxt_ports[2])
    );
    // port 3
    strobe_port_gate #(.PORT_NUM(`ROUTE_PORT_3)) gate_3 (
        .chosen(chosen),
        .route(strobe_port_route_ff),
        .enable(port_on_ff[3]),
        .drive(nxt_ports[3])
    );

    // output flops, one pe clock per step
    // one register stage keeps the same latency for every code, so zero relative offset holds
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strobe_port_0 <= 1'b0;
            strobe_port_1 <= 1'b0;
            strobe_port_2 <= 1'b0;
            strobe_port_3 <= 1'b0;
        end else begin
            strobe_port_0 <= nxt_ports[0];
            strobe_port_1 <= nxt_ports[1];
            strobe_port_2 <= nxt_ports[2];
            strobe_port_3 <= nxt_ports[3];
        end
    end

endmodule // strobe_seg_regs

// one strobe port gate: passes the chosen signal when routed here and enabled
// purely combinational; the caller registers the result
module strobe_port_gate #(
    parameter [1:0] PORT_NUM = 2'h0
) (
    input wire chosen,
    input wire [1:0] route,
    input wire enable,
    output wire drive
);
    wire routed_here;

    // route match first, then a cleared enable wins over any routing
    assign routed_here = (route == PORT_NUM);
    assign drive = chosen && routed_here && enable;
endmodule // strobe_port_gate

// ### bench/strobe_seg_regs_asserts.sv
// checker for strobe_seg_regs: apb writes, segment flags, strobe routing
// assumes the bind at the foot and pclk as the only clock
module strobe_seg_regs_asserts (
    input wire pclk, presetn, psel, penable, pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire pslverr, cycle_start, minislot_start,
    input wire [10:0] slot_count_b,
    input wire strobe_port_0, strobe_port_1, strobe_port_2, strobe_port_3,
    input wire [6:0] first_segment_size, second_segment_size, first_segment_end, last_used_buffer,
    input wire second_segment_empty
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [9:0] sel_ff;
    logic [3:0] en_ff;
    wire wr = psel && penable && pwrite;
    wire slot_bit = slot_count_b[sel_ff[3:0] - 4'h1];
    // shadow of routing writes, so strobe checks know what the port carries
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_ff <= 10'h000;
            en_ff <= 4'h0;
        end else if (wr && paddr == 12'h00c) sel_ff <= {pwdata[9:8], 1'b0, pwdata[6:0]};
        else if (wr && paddr == 12'h000) en_ff <= pwdata[3:0];
    end
    size_write_a: assert property (wr && paddr == 12'h004 |=>
        {17'h0, second_segment_size, 1'b0, first_segment_size} == ($past(pwdata) & 32'h7f7f)) else $error("size lost");
    split_write_a: assert property (wr && paddr == 12'h008 |=>
        {17'h0, first_segment_end, 1'b0, last_used_buffer} == ($past(pwdata) & 32'h7f7f)) else $error("split lost");
    seg_empty_a: assert property (second_segment_empty ==
        (first_segment_end == 7'h7f || last_used_buffer <= first_segment_end)) else $error("empty flag");
    unmapped_a: assert property (psel && penable && paddr > 12'h014 |-> pslverr) else $error("no slave error");
    gate_off_a: assert property (!en_ff[1] |=> !strobe_port_1) else $error("port active");
    cycle_pulse_a: assert property (sel_ff == 10'h04c && en_ff[0] |=>
        strobe_port_0 == $past(cycle_start)) else $error("cycle strobe");
    minislot_a: assert property (sel_ff == 10'h24f && en_ff[2] |=>
        strobe_port_2 == $past(minislot_start)) else $error("minislot strobe");
    slot_bit_a: assert property (sel_ff[9:8] == 2'h3 && sel_ff[6:0] inside {[7'h41:7'h4b]} && en_ff[3] |=>
        strobe_port_3 == $past(slot_bit)) else $error("slot bit");
    cover property (wr && paddr == 12'h00c);
    cover property (strobe_port_0);
    cover property (second_segment_empty ##1 !second_segment_empty);
endmodule // strobe_seg_regs_asserts
bind strobe_seg_regs strobe_seg_regs_asserts chk_i (.*);

// ### bench/strobe_probe.sv
// debug instrument: counts the cycles each strobe port is seen high
// assumes the ports are sampled on the block's own clock
module strobe_probe (
    input wire pclk,
    input wire [3:0] ports,
    output logic [7:0] hits [4]
);
    timeunit 1ns;
    timeprecision 1ps;
    // sample on the rising edge, as a scope on the pins would
    initial for (int p = 0; p < 4; p++) hits[p] = 8'h00;
    always @(posedge pclk) for (int p = 0; p < 4; p++) if (ports[p] === 1'b1) hits[p] <= hits[p] + 8'h01;
endmodule // strobe_probe

// ### bench/strobe_and_buffer_segment_config_bench.sv
// bench for strobe_seg_regs: register access, segment flags, strobe ports
// assumes the bound checker and the probe on the four ports
module strobe_and_buffer_segment_config_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, cycle_start = 1'b0;
    logic minislot_start = 1'b0, err;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, q;
    logic [10:0] slot_count_b = 11'h5a3;
    logic [7:0] hits [4];
    logic [7:0] h;
    wire [31:0] prdata;
    wire pready, pslverr, strobe_port_0, strobe_port_1, strobe_port_2, strobe_port_3, second_segment_empty;
    wire [6:0] first_segment_size, second_segment_size, first_segment_end, last_used_buffer;
    int n_fail = 0, checks = 0;
    strobe_seg_regs DUT (.*);
    strobe_probe probe (.pclk(pclk), .ports({strobe_port_3, strobe_port_2, strobe_port_1, strobe_port_0}), .hits(hits));
    initial forever #10 pclk = ~pclk;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // one apb transfer; the leading edge keeps a release and a new setup apart
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'b1 && i < 20);
        if (i >= 20) n_fail++;
        if (i >= 20) stop_test();
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic pulse(input logic m);
        @(posedge pclk);
        if (m) minislot_start <= 1'b1;
        else cycle_start <= 1'b1;
        @(posedge pclk);
        minislot_start <= 1'b0;
        cycle_start <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask
    task automatic regs_test;
        xfer(1'b0, 12'h000, 32'h0);
        chk(q, 32'h0);
        xfer(1'b1, 12'h004, 32'hffff_ffff);
        xfer(1'b0, 12'h004, 32'h0);
        chk(q, 32'h0000_7f7f);
        xfer(1'b1, 12'h004, 32'h0000_1234);
        @(negedge pclk);
        chk({second_segment_size, first_segment_size}, {7'h12, 7'h34});
        xfer(1'b0, 12'h01c, 32'h0);
        chk(q, 32'h0);
        chk(err, 32'h1);
    endtask
    // query buffers against split 5/9, then against split 5/5 where segment two is empty
    task automatic info_test;
        logic [6:0] qs [4] = '{7'h07, 7'h0a, 7'h03, 7'h07};
        logic [31:0] want [4] = '{32'h1203, 32'h1202, 32'h3401, 32'h1204};
        for (int k = 0; k < 4; k++) begin
            xfer(1'b1, 12'h008, (k < 3) ? 32'h0000_0509 : 32'h0000_0505);
            xfer(1'b1, 12'h010, {25'h0, qs[k]});
            xfer(1'b0, 12'h014, 32'h0);
            chk(q, want[k]);
        end
        chk(pready, 32'h1);
    endtask
    task automatic seg_test;
        logic [15:0] cs [4] = '{16'h7f7f, 16'h0505, 16'h0509, 16'h0001};
        for (int k = 0; k < 4; k++) begin
            xfer(1'b1, 12'h008, {16'h0, cs[k]});
            @(negedge pclk);
            chk({first_segment_end, last_used_buffer, second_segment_empty}, {cs[k][14:8], cs[k][6:0], k < 2});
        end
    endtask
    task automatic strobe_test;
        xfer(1'b1, 12'h000, 32'h0000_000f);
        xfer(1'b1, 12'h00c, 32'h0000_004c);
        h = hits[0];
        pulse(1'b0);
        chk(hits[0] - h, 32'h1);
        xfer(1'b1, 12'h000, 32'h0000_000e);
        h = hits[0];
        pulse(1'b0);
        chk(hits[0] - h, 32'h0);
        xfer(1'b1, 12'h00c, 32'h0000_024f);
        h = hits[2];
        pulse(1'b1);
        chk(hits[2] - h, 32'h1);
        // walk all slot bits, then again with the counter inverted
        for (int k = 0; k < 22; k++) begin
            xfer(1'b1, 12'h00c, 32'h0000_0341 + k % 11);
            if (k == 11) slot_count_b <= ~slot_count_b;
            repeat (2) @(negedge pclk);
            chk(strobe_port_3, slot_count_b[k % 11]);
        end
    endtask
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        regs_test();
        seg_test();
        info_test();
        strobe_test();
        stop_test();
    end
    // watchdog: a hang counts as a mismatch
    initial begin
        repeat (20000) @(posedge pclk);
        n_fail++;
        stop_test();
    end
endmodule // strobe_and_buffer_segment_config_bench
